/* File: gscd_map.svh */
// Constants for the gateway switch configuration decoder
// What this block does
// - Protocol switches select four field protocols
// - Alternate variant ignores protocol switch bank
// - BACnet instance equals base plus node
// - Instance base offset resets to 50000
// - TCP and N2 node identifier equals node
// - One station address for whole gateway
// - MS/TP station address from eight switches
// - Station switches ignored in TCP and N2
// - Rate switches decode five MS/TP rates
// - Alternate variant ignores rate switch bank
// - N2 mode fixes field rate 9600
// - Field rate independent of downstream rate
// - Downstream link 19200 baud, 8E1
// - Base offset accepts 0 to 4194303
`ifndef GSCD_MAP_SVH
`define GSCD_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GSCD_OFS_STATUS 8'h00
`define GSCD_OFS_STATION 8'h04
`define GSCD_OFS_FIELD_RATE 8'h08
`define GSCD_OFS_RTU_LINK 8'h0C
`define GSCD_OFS_BASE 8'h10
`define GSCD_OFS_UNIT_EN 8'h14
`define GSCD_OFS_UNIT_ADDR 8'h20
`define GSCD_OFS_UNIT_INST 8'h40
`define GSCD_OFS_UNIT_NODE 8'h60

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define GSCD_BASE_RESET 22'd50000
`define GSCD_BASE_MAX 22'd4194303
`define GSCD_NODE_MIN 7'd1
`define GSCD_NODE_MAX 7'd127
`define GSCD_STATION_MAX 8'd127

// ----------------------------------------
// Switch codes
// ----------------------------------------
`define GSCD_PSEL_BIP 4'h0
`define GSCD_PSEL_MSTP 4'h1
`define GSCD_PSEL_MTCP 4'h2
`define GSCD_PSEL_N2 4'h3
`define GSCD_RSEL_9600 4'h7
`define GSCD_RSEL_19200 4'h8
`define GSCD_RSEL_38400 4'hB
`define GSCD_RSEL_57600 4'hC
`define GSCD_RSEL_76800 4'hD

// ----------------------------------------
// Rates and downstream link format
// ----------------------------------------
`define GSCD_BAUD_9600 17'd9600
`define GSCD_BAUD_19200 17'd19200
`define GSCD_BAUD_38400 17'd38400
`define GSCD_BAUD_57600 17'd57600
`define GSCD_BAUD_76800 17'd76800
`define GSCD_RTU_BAUD 17'd19200
`define GSCD_RTU_DATA_BITS 4'd8
`define GSCD_RTU_STOP_BITS 2'd1
`define GSCD_RTU_PARITY_EVEN 2'd2

// ----------------------------------------
// Status fields and timing
// ----------------------------------------
`define GSCD_ST_PROTO_LSB 0
`define GSCD_ST_VALID_BIT 3
`define GSCD_ST_ALT_BIT 4
`define GSCD_ST_STATION_OK_BIT 5
`define GSCD_ST_RATE_OK_BIT 6
`define GSCD_SETTLE_CYCLES 5'd16
`define GSCD_UNITS 8

`endif

/* File: gscd_pkg.sv */
// Types for the gateway switch configuration decoder
package gscd_pkg;

	typedef enum logic [2:0]
	{
		GSCD_PROTO_BIP = 3'b000,
		GSCD_PROTO_MSTP = 3'b001,
		GSCD_PROTO_MTCP = 3'b010,
		GSCD_PROTO_N2 = 3'b011,
		GSCD_PROTO_ALT = 3'b100
	} gscd_proto_t;

	typedef struct packed
	{
		logic alt_variant;
		logic [3:0] field_rate;
		logic [7:0] station_addr;
		logic [3:0] proto_sel;
	} gscd_switch_t;

	typedef struct packed
	{
		logic cfg_valid;
		gscd_proto_t proto;
		logic [16:0] field_baud;
		logic field_rate_ok;
		logic [7:0] station_addr;
		logic station_ok;
	} gscd_cfg_t;

	typedef struct packed
	{
		logic [16:0] baud;
		logic [3:0] data_bits;
		logic [1:0] stop_bits;
		logic [1:0] parity;
	} gscd_rtu_t;

endpackage

/* File: gscd_sw_model.sv */
// Installer switch banks seen by the decoder
`timescale 1ns/1ps

module gscd_sw_model
(
	// Clock and power
	input wire logic ref_clk,
	input wire logic nrst,
	// Setting the installer wants
	input gscd_pkg::gscd_switch_t want,
	// Switch banks
	output logic [3:0] proto_sel_sw,
	output logic [7:0] station_addr_sw,
	output logic [3:0] field_rate_sw,
	output logic alt_variant_strap
);
	// Banks move only while the board is unpowered
	// Station and rate banks set as the scenario asks, faults included
	always_ff @(posedge ref_clk)
		if (!nrst)
			{alt_variant_strap, field_rate_sw, station_addr_sw, proto_sel_sw} <= want;
endmodule // gscd_sw_model

/* File: gscd_top.sv */
// Switch sampling, field configuration decode and AXI4-Lite register file
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "gscd_map.svh"

module gscd_top
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Switch banks and variant strap
	input wire logic [3:0] proto_sel_sw,
	input wire logic [7:0] station_addr_sw,
	input wire logic [3:0] field_rate_sw,
	input wire logic alt_variant_strap,
	// Decoded configuration
	output gscd_pkg::gscd_cfg_t cfg_out,
	output gscd_pkg::gscd_rtu_t rtu_link,
	// AXI4-Lite write channels
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------
	function automatic gscd_pkg::gscd_proto_t decode_proto(input logic [3:0] sw, input logic alt);
		if (alt)
			decode_proto = gscd_pkg::GSCD_PROTO_ALT;
		else
			case (sw)
				`GSCD_PSEL_MSTP: decode_proto = gscd_pkg::GSCD_PROTO_MSTP;
				`GSCD_PSEL_MTCP: decode_proto = gscd_pkg::GSCD_PROTO_MTCP;
				`GSCD_PSEL_N2: decode_proto = gscd_pkg::GSCD_PROTO_N2;
				default: decode_proto = gscd_pkg::GSCD_PROTO_BIP;
			endcase
	endfunction

	function automatic logic [17:0] decode_rate(input logic [3:0] sw);
		case (sw)
			`GSCD_RSEL_9600: decode_rate = {1'b1, `GSCD_BAUD_9600};
			`GSCD_RSEL_19200: decode_rate = {1'b1, `GSCD_BAUD_19200};
			`GSCD_RSEL_38400: decode_rate = {1'b1, `GSCD_BAUD_38400};
			`GSCD_RSEL_57600: decode_rate = {1'b1, `GSCD_BAUD_57600};
			`GSCD_RSEL_76800: decode_rate = {1'b1, `GSCD_BAUD_76800};
			default: decode_rate = 18'h00000;
		endcase
	endfunction

	function automatic logic node_ok(input logic [6:0] a);
		node_ok = (a >= `GSCD_NODE_MIN) && (a <= `GSCD_NODE_MAX);
	endfunction

	// ----------------------------------------
	// Switch synchroniser and power-up capture
	// ----------------------------------------
	gscd_pkg::gscd_switch_t sw_s1_reg;
	gscd_pkg::gscd_switch_t sw_s2_reg;
	gscd_pkg::gscd_switch_t sw_s3_reg;
	gscd_pkg::gscd_switch_t sw_cap_reg;
	logic [4:0] settle_reg;
	logic captured_reg;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sw_s1_reg <= '0;
			sw_s2_reg <= '0;
			sw_s3_reg <= '0;
		end
		else
		begin
			sw_s1_reg <= {alt_variant_strap, field_rate_sw, station_addr_sw, proto_sel_sw};
			sw_s2_reg <= sw_s1_reg;
			sw_s3_reg <= sw_s2_reg;
		end
	end

	// Stable run before capture rides out contact bounce at power-up
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			settle_reg <= 5'h00;
			captured_reg <= 1'b0;
			sw_cap_reg <= '0;
		end
		else if (!captured_reg)
		begin
			if (sw_s2_reg != sw_s3_reg)
				settle_reg <= 5'h00;
			else if (settle_reg == `GSCD_SETTLE_CYCLES)
			begin
				sw_cap_reg <= sw_s3_reg;
				captured_reg <= 1'b1;
			end
			else
				settle_reg <= settle_reg + 5'h01;
		end
	end

	// ----------------------------------------
	// Configuration decode
	// ----------------------------------------
	gscd_pkg::gscd_proto_t proto_next;
	logic [17:0] rate_next;
	gscd_pkg::gscd_cfg_t cfg_next;

	always_comb
	begin
		proto_next = decode_proto(sw_cap_reg.proto_sel, sw_cap_reg.alt_variant);
		rate_next = decode_rate(sw_cap_reg.field_rate);
		cfg_next = '0;
		cfg_next.cfg_valid = captured_reg;
		cfg_next.proto = proto_next;
		case (proto_next)
			gscd_pkg::GSCD_PROTO_MSTP:
			begin
				cfg_next.field_baud = rate_next[16:0];
				cfg_next.field_rate_ok = rate_next[17];
				cfg_next.station_addr = sw_cap_reg.station_addr;
				cfg_next.station_ok = (sw_cap_reg.station_addr != 8'h00)
					&& (sw_cap_reg.station_addr <= `GSCD_STATION_MAX);
			end
			gscd_pkg::GSCD_PROTO_N2:
			begin
				cfg_next.field_baud = `GSCD_BAUD_9600;
				cfg_next.field_rate_ok = 1'b1;
			end
			default:
			begin
				// Rate bank ignored on the alternate variant and the IP modes
				cfg_next.field_baud = 17'h00000;
				cfg_next.field_rate_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			cfg_out <= '0;
		else
			cfg_out <= cfg_next;
	end

	// Downstream format is fixed and never follows the field rate
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			rtu_link <= '0;
		else
		begin
			rtu_link.baud <= `GSCD_RTU_BAUD;
			rtu_link.data_bits <= `GSCD_RTU_DATA_BITS;
			rtu_link.stop_bits <= `GSCD_RTU_STOP_BITS;
			rtu_link.parity <= `GSCD_RTU_PARITY_EVEN;
		end
	end

	// ----------------------------------------
	// Software configuration registers
	// ----------------------------------------
	logic [21:0] base_reg;
	logic [7:0] unit_en_reg;
	logic [6:0] unit_addr_reg [0:`GSCD_UNITS-1];
	logic [7:0] aw_addr_reg;
	logic aw_hold_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_hold_reg;
	logic do_write;
	logic wr_hit;

	assign do_write = aw_hold_reg && w_hold_reg && !bvalid;
	assign wr_hit = (aw_addr_reg[7:2] == 6'(`GSCD_OFS_BASE >> 2))
		|| (aw_addr_reg[7:2] == 6'(`GSCD_OFS_UNIT_EN >> 2))
		|| (aw_addr_reg[7:5] == 3'h1);

	// Whole 22-bit field is legal, bits above 21 of the word are dropped
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			base_reg <= `GSCD_BASE_RESET;
			unit_en_reg <= 8'h00;
		end
		else if (do_write)
		begin
			if (aw_addr_reg == `GSCD_OFS_BASE)
			begin
				if (w_strb_reg[0])
					base_reg[7:0] <= w_data_reg[7:0];
				if (w_strb_reg[1])
					base_reg[15:8] <= w_data_reg[15:8];
				if (w_strb_reg[2])
					base_reg[21:16] <= w_data_reg[21:16];
			end
			if (aw_addr_reg == `GSCD_OFS_UNIT_EN && w_strb_reg[0])
				unit_en_reg <= w_data_reg[7:0];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < `GSCD_UNITS; i++)
				unit_addr_reg[i] <= 7'h00;
		end
		else if (do_write && aw_addr_reg[7:5] == 3'h1 && w_strb_reg[0])
			unit_addr_reg[aw_addr_reg[4:2]] <= w_data_reg[6:0];
	end

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_addr_reg <= {awaddr[7:2], 2'b00};
				aw_hold_reg <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
				w_hold_reg <= 1'b1;
				wready <= 1'b0;
			end
			if (do_write)
			begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? 2'h0 : 2'h2;
			end
			else if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	logic [31:0] rd_word;
	logic rd_hit;
	logic [2:0] rd_unit;
	logic [6:0] rd_node;
	logic rd_live;

	always_comb
	begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		rd_unit = araddr[4:2];
		rd_node = unit_addr_reg[rd_unit];
		rd_live = unit_en_reg[rd_unit] && node_ok(rd_node);
		case (araddr[7:5])
			3'h0:
				case ({3'h0, rd_unit, 2'b00})
					`GSCD_OFS_STATUS: rd_word = {25'h0, cfg_out.field_rate_ok,
						cfg_out.station_ok, sw_cap_reg.alt_variant, cfg_out.cfg_valid,
						cfg_out.proto};
					`GSCD_OFS_STATION: rd_word = {24'h0, cfg_out.station_addr};
					`GSCD_OFS_FIELD_RATE: rd_word = {15'h0, cfg_out.field_baud};
					`GSCD_OFS_RTU_LINK: rd_word = {7'h0, rtu_link};
					`GSCD_OFS_BASE: rd_word = {10'h0, base_reg};
					`GSCD_OFS_UNIT_EN: rd_word = {24'h0, unit_en_reg};
					default: rd_hit = 1'b0;
				endcase
			3'h1: rd_word = {25'h0, rd_node};
			3'h2:
				if (rd_live && (cfg_out.proto == gscd_pkg::GSCD_PROTO_BIP
					|| cfg_out.proto == gscd_pkg::GSCD_PROTO_MSTP))
					rd_word = {9'h0, 23'(base_reg) + 23'(rd_node)};
			3'h3:
				if (rd_live && (cfg_out.proto == gscd_pkg::GSCD_PROTO_MTCP
					|| cfg_out.proto == gscd_pkg::GSCD_PROTO_N2))
					rd_word = {25'h0, rd_node};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'h0;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_hit ? rd_word : 32'h00000000;
			rresp <= rd_hit ? 2'h0 : 2'h2;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule // gscd_top

/* File: gscd_top_asserts.sv */
// Concurrent checks on the decoded gateway configuration
`timescale 1ns/1ps

module gscd_top_asserts
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Switch banks
	input wire logic [3:0] proto_sel_sw,
	input wire logic [7:0] station_addr_sw,
	input wire logic [3:0] field_rate_sw,
	input wire logic alt_variant_strap,
	// Decoded outputs
	input gscd_pkg::gscd_cfg_t cfg_out,
	input gscd_pkg::gscd_rtu_t rtu_link
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	logic v;
	logic [2:0] p;
	assign v = cfg_out.cfg_valid;
	assign p = cfg_out.proto;
	property p_hold;
		v |=> $stable(cfg_out);
	endproperty
	property p_rtu;
		nrst |=> rtu_link == {17'h04B00, 4'h8, 2'h1, 2'h2};
	endproperty
	property p_proto;
		v && !alt_variant_strap |-> p == (proto_sel_sw < 4'h4 ? proto_sel_sw[2:0] : 3'h0);
	endproperty
	property p_alt;
		v && alt_variant_strap |-> p == 3'h4;
	endproperty
	property p_station;
		v && p == 3'h1 |-> cfg_out.station_addr == station_addr_sw
			&& cfg_out.station_ok == (station_addr_sw != 8'h00 && !station_addr_sw[7]);
	endproperty
	property p_station_off;
		v && (p == 3'h2 || p == 3'h3) |-> cfg_out.station_addr == 8'h00;
	endproperty
	property p_n2_rate;
		v && p == 3'h3 |-> cfg_out.field_baud == 17'h02580 && cfg_out.field_rate_ok;
	endproperty
	property p_alt_rate;
		v && p == 3'h4 |-> cfg_out.field_baud == 17'h00000 && !cfg_out.field_rate_ok;
	endproperty
	property p_fast_rate;
		v && p == 3'h1 && field_rate_sw == 4'hD |-> cfg_out.field_baud == 17'h12C00;
	endproperty
	property p_bad_rate;
		v && p == 3'h1 && !(field_rate_sw inside {4'h7, 4'h8, 4'hB, 4'hC, 4'hD})
			|-> !cfg_out.field_rate_ok;
	endproperty
	property p_capture;
		$rose(nrst) |-> (!v) [*8] ##[1:30] v;
	endproperty
	a_hold: assert property (p_hold) else $error("config moved");
	a_rtu: assert property (p_rtu) else $error("rtu format");
	a_proto: assert property (p_proto) else $error("proto decode");
	a_alt: assert property (p_alt) else $error("alt proto");
	a_station: assert property (p_station) else $error("station");
	a_station_off: assert property (p_station_off) else $error("station off");
	a_n2_rate: assert property (p_n2_rate) else $error("n2 rate");
	a_alt_rate: assert property (p_alt_rate) else $error("alt rate");
	a_fast_rate: assert property (p_fast_rate) else $error("mstp rate");
	a_bad_rate: assert property (p_bad_rate) else $error("bad rate");
	a_capture: assert property (p_capture) else $error("capture time");
	c_mstp: cover property (v && p == 3'h1 && cfg_out.station_ok);
	c_n2: cover property (v && p == 3'h3);
	c_alt: cover property (v && p == 3'h4);
	c_mtcp: cover property (v && p == 3'h2);
endmodule // gscd_top_asserts

bind gscd_top gscd_top_asserts i_chk (.ref_clk(ref_clk), .nrst(nrst),
	.proto_sel_sw(proto_sel_sw), .station_addr_sw(station_addr_sw),
	.field_rate_sw(field_rate_sw), .alt_variant_strap(alt_variant_strap),
	.cfg_out(cfg_out), .rtu_link(rtu_link));

/* File: tb_gateway_switch_config_decoder.sv */
// Self-checking bench for the gateway switch configuration decoder
`timescale 1ns/1ps

`define CHK(act, exp) \
	begin \
		comparisons++; \
		if ((act) !== (exp)) \
		begin \
			n_fail++; \
			$display("FAIL %0t got %h want %h", $time, act, exp); \
		end \
	end

module tb_gateway_switch_config_decoder;
	logic ref_clk = 1'b0, nrst = 1'b0, seen = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000, lfsr = 32'h00005E53, rdata;
	logic [3:0] proto_sel_sw, field_rate_sw;
	logic [3:0] wstrb = 4'hF;
	logic [7:0] station_addr_sw;
	logic alt_variant_strap, awready, wready, bvalid, arready, rvalid, ip, nd;
	logic [1:0] bresp, rresp, eb;
	logic [6:0] a;
	logic [33:0] er;
	logic [33:0] q_r[$];
	logic [1:0] q_b[$];
	gscd_pkg::gscd_cfg_t q_c[$];
	gscd_pkg::gscd_cfg_t cfg_out, c, ec;
	gscd_pkg::gscd_rtu_t rtu_link;
	gscd_pkg::gscd_switch_t want = '0, sw;
	int n_fail = 0, comparisons = 0, cyc = 0;
	// Strap, rate bank, protocol bank; station bank comes from the random source
	logic [8:0] cases [12] = '{9'h000, 9'h071, 9'h081, 9'h0B1, 9'h0C1, 9'h0D1,
		9'h0F1, 9'h072, 9'h0D3, 9'h005, 9'h07F, 9'h171};

	gscd_sw_model i_sw (.ref_clk(ref_clk), .nrst(nrst), .want(want),
		.proto_sel_sw(proto_sel_sw), .station_addr_sw(station_addr_sw),
		.field_rate_sw(field_rate_sw), .alt_variant_strap(alt_variant_strap));

	gscd_top i_dut (.ref_clk(ref_clk), .nrst(nrst), .proto_sel_sw(proto_sel_sw),
		.station_addr_sw(station_addr_sw), .field_rate_sw(field_rate_sw),
		.alt_variant_strap(alt_variant_strap), .cfg_out(cfg_out), .rtu_link(rtu_link),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	initial
		forever #25 ref_clk = ~ref_clk;

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic gscd_pkg::gscd_cfg_t exp_cfg(input gscd_pkg::gscd_switch_t s);
		gscd_pkg::gscd_cfg_t e;
		logic [2:0] p;
		e = '0;
		e.cfg_valid = 1'b1;
		p = s.alt_variant ? 3'h4 : (s.proto_sel < 4'h4 ? s.proto_sel[2:0] : 3'h0);
		e.proto = gscd_pkg::gscd_proto_t'(p);
		if (p == 3'h1)
		begin
			e.station_addr = s.station_addr;
			e.station_ok = s.station_addr inside {[8'h01:8'h7F]};
			case (s.field_rate)
				4'h7: e.field_baud = 17'h02580;
				4'h8: e.field_baud = 17'h04B00;
				4'hB: e.field_baud = 17'h09600;
				4'hC: e.field_baud = 17'h0E100;
				4'hD: e.field_baud = 17'h12C00;
				default: e.field_baud = 17'h00000;
			endcase
			e.field_rate_ok = e.field_baud != 17'h00000;
		end
		if (p == 3'h3)
		begin
			e.field_baud = 17'h02580;
			e.field_rate_ok = 1'b1;
		end
		return e;
	endfunction

	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r,
		input logic [3:0] s = 4'hF);
		q_b.push_back(r);
		@(posedge ref_clk);
		awaddr <= ad;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [33:0] e);
		q_r.push_back(e);
		@(posedge ref_clk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
	endtask

	task automatic stop_test();
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Results are taken off the queues as they appear at the ports
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_fail++;
			stop_test();
		end
		if (rvalid && rready)
		begin
			er = q_r.pop_front();
			`CHK({rresp, rdata}, er)
		end
		if (bvalid && bready)
		begin
			eb = q_b.pop_front();
			`CHK(bresp, eb)
		end
		if (cfg_out.cfg_valid && !seen)
		begin
			ec = q_c.pop_front();
			`CHK(cfg_out, ec)
		end
		seen = cfg_out.cfg_valid;
	end

	initial
	begin
		for (int i = 0; i < 12; i++)
		begin
			lfsr = nxt(lfsr);
			sw = {cases[i][8:4], lfsr[7:0], cases[i][3:0]};
			c = exp_cfg(sw);
			q_c.push_back(c);
			@(posedge ref_clk);
			nrst <= 1'b0;
			want <= sw;
			repeat (2) @(posedge ref_clk);
			nrst <= 1'b1;
			repeat (60) if (cfg_out.cfg_valid !== 1'b1) @(posedge ref_clk);
			ip = c.proto < 3'h2;
			nd = c.proto == 3'h2 || c.proto == 3'h3;
			rd(8'h00, {27'h0, c.field_rate_ok, c.station_ok, sw.alt_variant, 1'b1, c.proto});
			rd(8'h04, {26'h0, c.station_addr});
			rd(8'h08, {17'h0, c.field_baud});
			rd(8'h0C, {2'h0, 32'h004B0086});
			rd(8'h10, {2'h0, 32'h0000C350});
			// Unique addresses, fewer than eight masters
			a = {1'b0, lfsr[14:9]} + 7'h01;
			wr(8'h14, 32'h00000007, 2'h0);
			wr(8'h20, {25'h0, a}, 2'h0);
			wr(8'h24, 32'h0000007F, 2'h0);
			wr(8'h2C, 32'h00000005, 2'h0);
			rd(8'h40, {2'h0, ip ? 32'h0000C350 + {25'h0, a} : 32'h0});
			rd(8'h60, {2'h0, nd ? {25'h0, a} : 32'h0});
			rd(8'h48, 34'h0);
			rd(8'h4C, 34'h0);
			wr(8'h10, 32'h003FFFFF, 2'h0);
			rd(8'h44, {2'h0, ip ? 32'h0040007E : 32'h0});
			rd(8'h64, {2'h0, nd ? 32'h0000007F : 32'h0});
			// Single byte lane clears only the middle byte of the base
			wr(8'h10, 32'h00000000, 2'h0, 4'h2);
			rd(8'h10, {2'h0, 32'h003F00FF});
			wr(8'h00, 32'h00000000, 2'h2);
			wr(8'hFC, 32'h00000001, 2'h2);
			rd(8'hFC, {2'h2, 32'h0});
		end
		@(posedge ref_clk);
		`CHK(q_r.size() + q_b.size() + q_c.size(), 0)
		stop_test();
	end
endmodule // tb_gateway_switch_config_decoder
